// File: eio_top.sv
// Implementation choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "eio_consts.svh"
module eio_top
  import eio_pkg::*;
#(
  parameter int unsigned BLINK_HALF  = `EIO_BLINK_HALF_CYCLES,
  parameter int unsigned LED_TH_NEAR = `EIO_LED_TH_NEAR,
  parameter int unsigned LED_TH_MID  = `EIO_LED_TH_MID
) (
  // Clock and reset
  input  wire logic               i_clock,
  input  wire logic               i_rstn,
  // Avalon-MM slave
  input  wire logic [7:0]         i_avs_address,
  input  wire logic               i_avs_read,
  input  wire logic               i_avs_write,
  input  wire logic [31:0]        i_avs_writedata,
  output logic [31:0]             o_avs_readdata,
  output logic                    o_avs_waitrequest,
  // Encoder pins, channel 0 is the line encoder
  input  wire logic [3:0]         i_enc_a,
  input  wire logic [3:0]         i_enc_b,
  // Control pins
  input  wire logic               i_clear_error,
  input  wire logic               i_control_enable,
  // Control loop, same clock
  input  wire logic signed [31:0] i_pos_error,
  input  wire logic [5:0]         i_digital_outputs,
  input  wire logic               i_error_detect,
  input  wire logic [47:0]        i_ana_demand,
  // Outputs
  output logic [63:0]             o_ana_mv,
  output logic                    o_pulse_a,
  output logic                    o_pulse_b,
  output logic [5:0]              o_led,
  output logic                    o_error,
  output logic                    o_irq
);
  localparam logic signed [31:0] TH_NEAR = 32'(LED_TH_NEAR);
  localparam logic signed [31:0] TH_MID  = 32'(LED_TH_MID);
  localparam logic [31:0]        BLINK_LAST = 32'(BLINK_HALF - 1);

  logic [31:0]      ctrl;
  logic [31:0]      vm_rate;
  logic [31:0]      vm_acc;
  logic [31:0]      vm_pos;
  logic [1:0]       vm_phase;
  logic [1:0]       irq_stat;
  logic [1:0]       irq_en;
  logic             ack;
  logic             err_pending;
  logic             clr_meta;
  logic             clr_sync;
  logic             en_meta;
  logic             en_sync;
  logic [31:0]      blink_cnt;
  logic             blink_on;
  logic [11:0]      offset [4];
  logic [10:0]      gain [4];
  logic [3:0][31:0] count;
  logic [3:0]       enc_a_sync;
  logic [3:0]       enc_b_sync;

  function automatic logic [31:0] eio_abs(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction

  function automatic logic [15:0] eio_scale(input logic [11:0] dem,
                                            input logic [11:0] off,
                                            input logic [10:0] g);
    logic signed [12:0] sum;
    logic signed [12:0] lim;
    logic signed [27:0] prod;
    sum  = 13'($signed(dem)) + 13'($signed(off));
    lim  = sum;
    if (sum > $signed(`EIO_ANA_LIMIT)) begin
      lim = $signed(`EIO_ANA_LIMIT);
    end else if (sum < -$signed(`EIO_ANA_LIMIT)) begin
      lim = -$signed(`EIO_ANA_LIMIT);
    end
    // 2047 counts taken as 2^11: under 0.05 % low at full scale, no divider
    prod = 28'(lim) * $signed({17'h0_0000, g}) * $signed(`EIO_MV_PER_CV);
    return 16'(prod >>> `EIO_ANA_SHIFT);
  endfunction

  // Bus decode
  logic        bus_req;
  logic        wr_fire;
  logic [3:0]  bank;
  logic [1:0]  chan;
  logic        wr_ctrl;
  logic        wr_rate;
  logic        wr_irq_clr;
  logic        wr_irq_en;
  logic        wr_offset;
  logic        wr_gain;
  logic [10:0] gain_wdata;
  logic [31:0] next_readdata;

  assign bus_req           = i_avs_read | i_avs_write;
  // One wait state: read data are latched while waitrequest is high
  assign o_avs_waitrequest = bus_req & ~ack;
  assign wr_fire           = i_avs_write & ack;
  assign bank              = i_avs_address[7:4];
  assign chan              = i_avs_address[3:2];
  assign wr_ctrl    = wr_fire && (i_avs_address == `EIO_ADDR_CTRL);
  assign wr_rate    = wr_fire && (i_avs_address == `EIO_ADDR_VM_RATE);
  assign wr_irq_clr = wr_fire && (i_avs_address == `EIO_ADDR_IRQ_CLR);
  assign wr_irq_en  = wr_fire && (i_avs_address == `EIO_ADDR_IRQ_EN);
  assign wr_offset  = wr_fire && (bank == `EIO_BANK_OFFSET) && (i_avs_address[1:0] == 2'h0);
  assign wr_gain    = wr_fire && (bank == `EIO_BANK_GAIN) && (i_avs_address[1:0] == 2'h0);
  assign gain_wdata = (i_avs_writedata > 32'(`EIO_GAIN_FULL)) ? `EIO_GAIN_FULL :
                      i_avs_writedata[10:0];

  always_comb begin
    next_readdata = 32'h0000_0000;
    if (i_avs_address == `EIO_ADDR_CTRL) begin
      next_readdata = ctrl;
    end else if (i_avs_address == `EIO_ADDR_VM_RATE) begin
      next_readdata = vm_rate;
    end else if (i_avs_address == `EIO_ADDR_ERR) begin
      next_readdata = {31'h0000_0000, err_pending};
    end else if (i_avs_address == `EIO_ADDR_IRQ_STAT) begin
      next_readdata = {30'h0000_0000, irq_stat};
    end else if (i_avs_address == `EIO_ADDR_IRQ_EN) begin
      next_readdata = {30'h0000_0000, irq_en};
    end else if (i_avs_address == `EIO_ADDR_POS_ERR) begin
      next_readdata = i_pos_error;
    end else if (i_avs_address == `EIO_ADDR_VM_POS) begin
      next_readdata = vm_pos;
    end else if (i_avs_address[1:0] != 2'h0) begin
      next_readdata = 32'h0000_0000;
    end else if (bank == `EIO_BANK_COUNT) begin
      next_readdata = count[chan];
    end else if (bank == `EIO_BANK_OFFSET) begin
      next_readdata = {{20{offset[chan][11]}}, offset[chan]};
    end else if (bank == `EIO_BANK_GAIN) begin
      next_readdata = {21'h00_0000, gain[chan]};
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ack            <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
      ctrl           <= `EIO_CTRL_RESET;
      vm_rate        <= 32'h0000_0000;
      irq_en         <= 2'h0;
    end else begin
      ack <= bus_req & ~ack;
      if (i_avs_read && !ack) begin
        o_avs_readdata <= next_readdata;
      end
      if (wr_ctrl) begin
        ctrl <= i_avs_writedata;
      end
      if (wr_rate) begin
        vm_rate <= i_avs_writedata;
      end
      if (wr_irq_en) begin
        irq_en <= i_avs_writedata[1:0];
      end
    end
  end

  // Analogue outputs
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < 4; i++) begin
        offset[i] <= `EIO_OFFSET_RESET;
        gain[i]   <= `EIO_GAIN_FULL;
      end
      o_ana_mv <= 64'h0000_0000_0000_0000;
    end else begin
      if (wr_offset) begin
        offset[chan] <= i_avs_writedata[11:0];
      end
      if (wr_gain) begin
        gain[chan] <= gain_wdata;
      end
      for (int i = 0; i < 4; i++) begin
        o_ana_mv[16*i +: 16] <= eio_scale(i_ana_demand[12*i +: 12],
                                          offset[i], gain[i]);
      end
    end
  end

  // Encoder counters
  for (genvar g = 0; g < 4; g++) begin : g_cnt
    eio_quad_counter u_cnt (
      .i_clock  (i_clock),
      .i_rstn   (i_rstn),
      .i_enc_a  (i_enc_a[g]),
      .i_enc_b  (i_enc_b[g]),
      .i_mult   (eio_mult_t'(ctrl[`EIO_CTRL_MULT_LSB + 2*g +: 2])),
      .i_invert (ctrl[`EIO_CTRL_INV_LSB + g]),
      .o_a      (enc_a_sync[g]),
      .o_b      (enc_b_sync[g]),
      .o_count  (count[g])
    );
  end

  // Virtual master: phase accumulator, one quadrature step per carry
  logic [32:0] vm_sum;
  logic        vm_dir;
  assign vm_sum = {1'b0, vm_acc} + {1'b0, vm_rate};
  assign vm_dir = ctrl[`EIO_CTRL_VM_DIR];

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      vm_acc   <= 32'h0000_0000;
      vm_pos   <= 32'h0000_0000;
      vm_phase <= 2'h0;
    end else begin
      vm_acc <= vm_sum[31:0];
      if (vm_sum[32]) begin
        // Phase runs backwards for forward so that A leads B
        vm_pos   <= vm_dir ? vm_pos + 32'h1 : vm_pos - 32'h1;
        vm_phase <= vm_dir ? vm_phase - 2'h1 : vm_phase + 2'h1;
      end
    end
  end

  logic next_pulse_a;
  logic next_pulse_b;
  assign next_pulse_a = ctrl[`EIO_CTRL_PULSE_SEL] ? vm_phase[1] : enc_a_sync[0];
  assign next_pulse_b = ctrl[`EIO_CTRL_PULSE_SEL] ? ^vm_phase : enc_b_sync[0];

  // Error state and interrupts
  logic       err_clear;
  logic       next_err;
  logic [1:0] irq_set;
  logic [1:0] irq_clr_mask;
  assign err_clear    = clr_sync | ~en_sync;
  // A new error in the clearing cycle wins
  assign next_err     = i_error_detect | (err_pending & ~err_clear);
  assign irq_set[`EIO_IRQ_ERR_SET] = next_err & ~err_pending;
  assign irq_set[`EIO_IRQ_ERR_CLR] = err_pending & ~next_err;
  assign irq_clr_mask = wr_irq_clr ? i_avs_writedata[1:0] : 2'h0;
  assign o_irq        = |(irq_stat & irq_en);
  assign o_error      = err_pending;

  // Indicator LEDs
  logic [31:0] err_mag;
  logic [1:0]  err_lvl;
  logic [5:0]  err_bar;
  logic [5:0]  next_led;
  assign err_mag  = eio_abs(i_pos_error);
  assign err_lvl  = (err_mag <= 32'(TH_NEAR)) ? 2'h0 :
                    (err_mag <= 32'(TH_MID)) ? 2'h1 : 2'h2;
  // Bit 5 is the leftmost LED
  assign err_bar  = i_pos_error[31] ? (6'h08 << err_lvl) : (6'h04 >> err_lvl);
  assign next_led = err_pending ? {6{blink_on}} :
                    ctrl[`EIO_CTRL_VIEW_SEL] ? err_bar :
                    i_digital_outputs;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      clr_meta    <= 1'b0;
      clr_sync    <= 1'b0;
      en_meta     <= 1'b0;
      en_sync     <= 1'b0;
      err_pending <= 1'b0;
      irq_stat    <= 2'h0;
      blink_cnt   <= 32'h0000_0000;
      blink_on    <= 1'b1;
      o_led       <= 6'h00;
      o_pulse_a   <= 1'b0;
      o_pulse_b   <= 1'b0;
    end else begin
      clr_meta    <= i_clear_error;
      clr_sync    <= clr_meta;
      en_meta     <= i_control_enable;
      en_sync     <= en_meta;
      err_pending <= next_err;
      irq_stat    <= irq_set | (irq_stat & ~irq_clr_mask);
      if (!err_pending || blink_cnt == BLINK_LAST) begin
        blink_cnt <= 32'h0000_0000;
      end else begin
        blink_cnt <= blink_cnt + 32'h1;
      end
      blink_on  <= !err_pending ? 1'b1 : (blink_cnt == BLINK_LAST) ? ~blink_on : blink_on;
      o_led     <= next_led;
      o_pulse_a <= next_pulse_a;
      o_pulse_b <= next_pulse_b;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  sequence s_err_held;
    o_error && en_sync && !clr_sync;
  endsequence
  sequence s_err_cleared;
    !i_error_detect && clr_sync;
  endsequence

  property p_err_set;
    i_error_detect |=> o_error ##1 (o_error || $past(err_clear));
  endproperty
  a_err_set: assert property (p_err_set) else $error("error not raised");

  property p_err_hold;
    s_err_held |=> o_error;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error dropped early");

  property p_err_clear;
    (o_error ##0 s_err_cleared) |=> !o_error;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error not cleared");

  property p_blink;
    err_pending |=> (o_led == 6'h3f || o_led == 6'h00);
  endproperty
  a_blink: assert property (p_blink) else $error("LEDs not blinking");

  property p_view_dig;
    (!err_pending && !ctrl[`EIO_CTRL_VIEW_SEL]) |=> (o_led == $past(i_digital_outputs));
  endproperty
  a_view_dig: assert property (p_view_dig) else $error("LEDs not digital outs");

  property p_bar_lag;
    (!err_pending && ctrl[`EIO_CTRL_VIEW_SEL] && i_pos_error > TH_MID) |=> (o_led == 6'h01);
  endproperty
  a_bar_lag: assert property (p_bar_lag) else $error("lag not at right end");

  property p_bar_lead;
    (!err_pending && ctrl[`EIO_CTRL_VIEW_SEL] && i_pos_error < -TH_MID) |=> (o_led == 6'h20);
  endproperty
  a_bar_lead: assert property (p_bar_lead) else $error("lead not at left end");

  property p_bar_centre;
    (!err_pending && ctrl[`EIO_CTRL_VIEW_SEL] && !i_pos_error[31] && i_pos_error <= TH_NEAR)
      |=> (o_led == 6'h04);
  endproperty
  a_bar_centre: assert property (p_bar_centre) else $error("small error off centre");

  property p_vm_dir;
    vm_sum[32] |=> (vm_pos == ($past(vm_dir) ? $past(vm_pos) + 32'h1 : $past(vm_pos) - 32'h1));
  endproperty
  a_vm_dir: assert property (p_vm_dir) else $error("virtual master direction");

  property p_pulse_line;
    !ctrl[`EIO_CTRL_PULSE_SEL] |=> (o_pulse_a == $past(enc_a_sync[0]) &&
                                    o_pulse_b == $past(enc_b_sync[0]));
  endproperty
  a_pulse_line: assert property (p_pulse_line) else $error("pulse not line input");

  property p_pulse_vm;
    ctrl[`EIO_CTRL_PULSE_SEL] |=> (o_pulse_a == $past(vm_phase[1]));
  endproperty
  a_pulse_vm: assert property (p_pulse_vm) else $error("pulse not virtual master");

  property p_ana_zero_gain;
    (gain[0] == 11'h000) |=> (o_ana_mv[15:0] == 16'h0000);
  endproperty
  a_ana_zero_gain: assert property (p_ana_zero_gain) else $error("gain 0 not 0 V");

  property p_ana_full;
    (gain[0] == `EIO_GAIN_FULL && offset[0] == 12'h7ff && i_ana_demand[11:0] == 12'h000)
      |=> (o_ana_mv[15:0] == 16'h270b);
  endproperty
  a_ana_full: assert property (p_ana_full) else $error("full offset not 9995 mV");

  property p_rd_count;
    (i_avs_read && !ack && i_avs_address == 8'h20) |=> (o_avs_readdata == $past(count[0]));
  endproperty
  a_rd_count: assert property (p_rd_count) else $error("count readback stale");
endmodule
`default_nettype wire

// File: eio_consts.svh
`ifndef EIO_CONSTS_SVH
`define EIO_CONSTS_SVH

// Counter width
`define EIO_COUNT_WIDTH 32

// Register byte offsets
`define EIO_ADDR_CTRL      8'h00
`define EIO_ADDR_VM_RATE   8'h04
`define EIO_ADDR_ERR       8'h08
`define EIO_ADDR_IRQ_STAT  8'h0c
`define EIO_ADDR_IRQ_CLR   8'h10
`define EIO_ADDR_IRQ_EN    8'h14
`define EIO_ADDR_POS_ERR   8'h18
`define EIO_ADDR_VM_POS    8'h1c
// Per-channel banks, selected by address bits 7:4, channel in bits 3:2
`define EIO_BANK_COUNT     4'h2
`define EIO_BANK_OFFSET    4'h3
`define EIO_BANK_GAIN      4'h4

// Control register fields
`define EIO_CTRL_MULT_LSB  0
`define EIO_CTRL_INV_LSB   8
`define EIO_CTRL_VM_DIR    12
`define EIO_CTRL_PULSE_SEL 13
`define EIO_CTRL_VIEW_SEL  14
`define EIO_CTRL_RESET     32'h0000_1000

// Interrupt status bits
`define EIO_IRQ_ERR_SET    0
`define EIO_IRQ_ERR_CLR    1

// Analogue scaling
`define EIO_ANA_LIMIT      13'h07ff
`define EIO_GAIN_FULL      11'h3e8
`define EIO_OFFSET_RESET   12'h000
`define EIO_MV_PER_CV      28'h00a
`define EIO_ANA_SHIFT      11

// Timing
`define EIO_CLK_PERIOD_NS   8
`define EIO_BLINK_PERIOD_MS 1000
`define EIO_BLINK_HALF_CYCLES \
  ((`EIO_BLINK_PERIOD_MS * 1000000) / `EIO_CLK_PERIOD_NS / 2)

// Position error display thresholds, encoder increments
`define EIO_LED_TH_NEAR    16
`define EIO_LED_TH_MID     64

`endif

// File: eio_pkg.sv
`default_nettype none
package eio_pkg;
  typedef enum logic [1:0] {
    EIO_MULT_X1,
    EIO_MULT_X2,
    EIO_MULT_X4,
    EIO_MULT_BAD
  } eio_mult_t;
endpackage
`default_nettype wire

// File: eio_quad_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "eio_consts.svh"
module eio_quad_counter
  import eio_pkg::*;
#(
  parameter int WIDTH = `EIO_COUNT_WIDTH
) (
  // Clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rstn,
  // Encoder pins
  input  wire logic             i_enc_a,
  input  wire logic             i_enc_b,
  // Settings
  input  wire eio_mult_t        i_mult,
  input  wire logic             i_invert,
  // Synchronised phases and count
  output logic                  o_a,
  output logic                  o_b,
  output logic [WIDTH-1:0]      o_count
);
  logic a_meta;
  logic b_meta;
  logic a_prev;
  logic b_prev;
  logic a_edge;
  logic b_edge;
  logic fwd;
  logic up;
  logic step;

  assign a_edge = o_a ^ a_prev;
  assign b_edge = o_b ^ b_prev;
  // Both phases moving at once is a glitch, never a count
  assign fwd    = a_edge ? (o_a ^ o_b) : ~(o_a ^ o_b);
  assign up     = fwd ^ i_invert;
  assign step   = (i_mult == EIO_MULT_X4) ? (a_edge ^ b_edge) :
                  (i_mult == EIO_MULT_X2) ? (a_edge & ~b_edge) :
                  (a_edge & o_a & ~b_edge);

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      a_meta  <= 1'b0;
      b_meta  <= 1'b0;
      o_a     <= 1'b0;
      o_b     <= 1'b0;
      a_prev  <= 1'b0;
      b_prev  <= 1'b0;
      o_count <= '0;
    end else begin
      a_meta <= i_enc_a;
      b_meta <= i_enc_b;
      o_a    <= a_meta;
      o_b    <= b_meta;
      a_prev <= o_a;
      b_prev <= o_b;
      if (step) begin
        o_count <= up ? o_count + WIDTH'(1) : o_count - WIDTH'(1);
      end
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  property p_x4_b_edge;
    (i_mult == EIO_MULT_X4 && b_edge && !a_edge) |=> (o_count != $past(o_count));
  endproperty
  a_x4_b_edge: assert property (p_x4_b_edge) else $error("x4 missed a B edge");

  property p_x2_a_fall;
    (i_mult == EIO_MULT_X2 && a_edge && !o_a && !b_edge) |=> (o_count != $past(o_count));
  endproperty
  a_x2_a_fall: assert property (p_x2_a_fall) else $error("x2 missed A fall");

  property p_x1_a_fall;
    (i_mult == EIO_MULT_X1 && a_edge && !o_a) |=> (o_count == $past(o_count));
  endproperty
  a_x1_a_fall: assert property (p_x1_a_fall) else $error("x1 counted A fall");

  property p_bad_code;
    (i_mult == EIO_MULT_BAD && b_edge) |=> (o_count == $past(o_count));
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad code not x1");

  property p_dir_up;
    (a_edge && !b_edge && o_a && !o_b && !i_invert) |=>
      (o_count == $past(o_count) + WIDTH'(1));
  endproperty
  a_dir_up: assert property (p_dir_up) else $error("A lead did not count up");

  property p_dir_inv;
    (a_edge && !b_edge && o_a && !o_b && i_invert) |=>
      (o_count == $past(o_count) - WIDTH'(1));
  endproperty
  a_dir_inv: assert property (p_dir_inv) else $error("invert did not count down");
endmodule
`default_nettype wire

// File: eio_enc_model.sv
`timescale 1ns/1ps
`default_nettype none
module eio_enc_model (
  // Step requests
  input  wire logic       i_clock,
  input  wire logic [3:0] i_step,
  input  wire logic [3:0] i_fwd,
  // Quadrature pins
  output logic [3:0]      o_a,
  output logic [3:0]      o_b
);
  logic [1:0] ph [4];
  initial ph = '{default: 2'h0};
  // One phase per step, so A and B never change together
  always @(posedge i_clock) begin
    for (int c = 0; c < 4; c++)
      if (i_step[c]) ph[c] <= i_fwd[c] ? ph[c] + 2'h1 : ph[c] - 2'h1;
  end
  // Gray order, A leads B when stepping forward
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      o_a[c] = ph[c][1] ^ ph[c][0];
      o_b[c] = ph[c][1];
    end
  end
endmodule
`default_nettype wire

// File: tb_eio_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_eio_top;
  logic i_clock = 0, rstn = 0, rd = 0, wr = 0, clr = 0, en = 1, edet = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rdq, q, p1, c0 [4];
  logic wq, pa, pb, err, irq;
  logic [3:0] ea, eb, st = 4'h0, dr = 4'h0, inv, dirs;
  logic signed [31:0] perr = 32'sh0;
  logic [5:0] dout = 6'h00, led;
  logic [47:0] dem = 48'h0;
  logic [63:0] mv;
  int failures = 0, checks_done = 0, seed = 67, tog = 0, on, off, o, g, d, e;
  int et [10] = '{0, -1, 16, -16, 17, -17, 64, -64, 65, -65};
  logic pa_d = 0;

  eio_top #(.BLINK_HALF(8)) eio_top_inst (.i_clock(i_clock), .i_rstn(rstn),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .o_avs_readdata(rdq), .o_avs_waitrequest(wq), .i_enc_a(ea), .i_enc_b(eb),
    .i_clear_error(clr), .i_control_enable(en), .i_pos_error(perr),
    .i_digital_outputs(dout), .i_error_detect(edet), .i_ana_demand(dem), .o_ana_mv(mv),
    .o_pulse_a(pa), .o_pulse_b(pb), .o_led(led), .o_error(err), .o_irq(irq));
  eio_enc_model eio_enc_model_inst (.i_clock(i_clock), .i_step(st), .i_fwd(dr),
    .o_a(ea), .o_b(eb));

  always #4 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    pa_d <= pa;
    if (pa !== pa_d) tog++;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  // Held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clock);
    adr <= a;
    wd <= v;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge i_clock);
    end while (wq !== 1'b0);
    q = rdq;
    wr <= 0;
    rd <= 0;
  endtask
  task automatic stp(input logic [3:0] f);
    @(posedge i_clock);
    st <= 4'hf;
    dr <= f;
    @(posedge i_clock);
    st <= 4'h0;
    repeat (6) @(posedge i_clock);
  endtask
  function automatic logic [31:0] cnt_exp(int m, logic up);
    logic [31:0] n;
    n = (m == 1) ? 2 : (m == 2) ? 4 : 1;
    return up ? n : -n;
  endfunction
  function automatic logic [31:0] ana_exp(int dd, int oo, int gg);
    int s;
    s = dd + oo;
    if (s > 2047) s = 2047;
    if (s < -2047) s = -2047;
    return {16'h0000, 16'((s * gg * 10) >>> 11)};
  endfunction
  function automatic logic [31:0] bar(int v);
    int a;
    a = (v < 0) ? -v : v;
    if (a <= 16) return (v >= 0) ? 32'h04 : 32'h08;
    if (a <= 64) return (v >= 0) ? 32'h02 : 32'h10;
    return (v >= 0) ? 32'h01 : 32'h20;
  endfunction

  initial begin
    // Whole run takes well under a thousand cycles
    repeat (20000) @(posedge i_clock);
    failures++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge i_clock);
    rstn <= 1;
    bus(0, 8'h00, 0); chk("ctrl", q, 32'h0000_1000);
    bus(0, 8'h40, 0); chk("gain", q, 32'h0000_03e8);
    bus(0, 8'hfc, 0); chk("unmapped", q, 32'h0);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      inv = $random(seed);
      dirs = $random(seed);
      bus(1, 8'h00, {20'h00001, inv, {4{2'(m)}}});
      for (int c = 0; c < 4; c++) begin
        bus(0, 8'(8'h20 + 4 * c), 0);
        c0[c] = q;
      end
      repeat (4) stp(dirs);
      for (int c = 0; c < 4; c++) begin
        bus(0, 8'(8'h20 + 4 * c), 0);
        chk("count", q - c0[c], cnt_exp(m, dirs[c] ^ inv[c]));
      end
    end
    stp(4'h1);
    chk("pulse a", {pa, pb}, {ea[0], eb[0]});
    $display("test counters done");
    for (int c = 0; c < 4; c++) begin
      o = (c == 0) ? 2047 : $random(seed) % 2048;
      g = (c == 0) ? 1000 : (c == 1) ? 1500 : {$random(seed)} % 1001;
      d = (c == 0) ? 2047 : $random(seed) % 2048;
      dem[12 * c +: 12] <= 12'(d);
      bus(1, 8'(8'h30 + 4 * c), 32'(o));
      bus(1, 8'(8'h40 + 4 * c), 32'(g));
      if (g > 1000) g = 1000;
      bus(0, 8'(8'h30 + 4 * c), 0); chk("offset", q, 32'(o));
      bus(0, 8'(8'h40 + 4 * c), 0); chk("gain", q, 32'(g));
      repeat (4) @(posedge i_clock);
      chk("ana", 32'(mv[16 * c +: 16]), ana_exp(d, o, g));
    end
    dem[11:0] <= 12'h000;
    repeat (4) @(posedge i_clock);
    chk("ana full", 32'(mv[15:0]), ana_exp(0, 2047, 1000));
    bus(1, 8'h40, 0);
    repeat (4) @(posedge i_clock);
    chk("ana zero", 32'(mv[15:0]), ana_exp(0, 2047, 0));
    $display("test analogue done");
    bus(1, 8'h04, 32'h4000_0000);
    for (int f = 1; f >= 0; f--) begin
      bus(1, 8'h00, {18'h0, 1'b1, 1'(f), 12'h000});
      bus(0, 8'h1c, 0);
      p1 = q;
      tog = 0;
      repeat (40) @(posedge i_clock);
      bus(0, 8'h1c, 0);
      chk("vm dir", 32'($signed(q - p1) > 0), 32'(f));
      chk("vm pulse", 32'(tog > 4), 32'h1);
    end
    $display("test virtual master done");
    for (int v = 0; v < 2; v++) begin
      bus(1, 8'h00, {17'h0, 1'(v), 14'h1000});
      for (int i = 0; i < 13; i++) begin
        e = (i < 10) ? et[i] : $random(seed) % 150;
        @(posedge i_clock);
        perr <= e;
        dout <= $random(seed);
        repeat (3) @(posedge i_clock);
        chk("led", 32'(led), v ? bar(e) : 32'(dout));
        bus(0, 8'h18, 0); chk("pos err", q, 32'(e));
      end
    end
    $display("test leds done");
    bus(1, 8'h14, 32'h3);
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clock);
      edet <= 1;
      @(posedge i_clock);
      edet <= 0;
      @(negedge i_clock);
      chk("error", 32'(err), 32'h1);
      chk("irq", 32'(irq), 32'(k == 0));
      on = 0;
      off = 0;
      repeat (20) begin
        @(negedge i_clock);
        if (led === 6'h3f) on++;
        if (led === 6'h00) off++;
      end
      chk("blink", 32'(on + off == 20 && on > 0 && off > 0), 32'h1);
      bus(0, 8'h08, 0); chk("err reg", q, 32'h1);
      @(posedge i_clock);
      if (k == 0) clr <= 1;
      else en <= 0;
      repeat (5) @(posedge i_clock);
      clr <= 0;
      en <= 1;
      @(negedge i_clock);
      chk("cleared", 32'(err), 32'h0);
      bus(0, 8'h0c, 0); chk("irq status", q, 32'h3);
      bus(1, 8'h10, 32'h3);
      bus(0, 8'h0c, 0); chk("irq status", q, 32'h0);
      bus(1, 8'h14, 32'h0);
    end
    $display("test error done");
    end_sim();
  end
endmodule
`default_nettype wire
